// file: dec_pkg.sv
package dec_pkg;

  // ****************************************************************
  // synchroniser depth and widths
  // ****************************************************************
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned CMD_W       = 3;
  localparam int unsigned MODE_W      = 3;

  // ****************************************************************
  // debugger commands carried from the link
  // ****************************************************************
  localparam logic [CMD_W-1:0] CMD_HALT = 3'h1;
  localparam logic [CMD_W-1:0] CMD_STEP = 3'h2;
  localparam logic [CMD_W-1:0] CMD_RUN  = 3'h3;
  localparam logic [CMD_W-1:0] CMD_FREE = 3'h4;
  localparam logic [CMD_W-1:0] CMD_SYNC = 3'h5;

  // ****************************************************************
  // latched operating modes
  // ****************************************************************
  localparam logic [MODE_W-1:0] MODE_PERIPH = 3'h0;
  localparam logic [MODE_W-1:0] MODE_TEST   = 3'h1;
  localparam logic [MODE_W-1:0] MODE_WAIT   = 3'h2;
  localparam logic [MODE_W-1:0] MODE_NORMAL = 3'h3;
  localparam logic [MODE_W-1:0] MODE_EMU    = 3'h4;

  // ****************************************************************
  // execution states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_HALT,
    ST_STEP,
    ST_RUN,
    ST_FREE,
    ST_SYNC
  } dec_state_e;

endpackage

// file: dec_exec_ctrl.sv
`timescale 1ns/100ps

module dec_exec_ctrl
  import dec_pkg::*;
#(
  parameter int unsigned N_IRQ  = 8,
  parameter int unsigned N_TRIG = 4
)(
  // core clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // link clock and link-side command pins
  input  wire logic              tck,
  input  wire logic              trst,
  input  wire logic              cmd_valid,
  input  wire logic [CMD_W-1:0]  cmd_code,
  input  wire logic              cmd_step_irq_allow,
  output logic                   cmd_ready,
  output logic                   link_halted,
  // debug pins, two-way
  input  wire logic              debug_pin0_i,
  output logic                   debug_pin0_o,
  output logic                   debug_pin0_oe,
  input  wire logic              debug_pin1_i,
  output logic                   debug_pin1_o,
  output logic                   debug_pin1_oe,
  // break sources from the pipeline and analysis_unit
  input  wire logic              insn_boundary,
  input  wire logic              hw_bp_d2,
  input  wire logic              sw_break_insn_d2,
  input  wire logic              halt_insn_d2,
  input  wire logic              watch_req,
  input  wire logic [N_TRIG-1:0] ext_trig,
  input  wire logic [N_TRIG-1:0] ext_trig_en,
  input  wire logic              sync_go,
  // interrupt handshake with the core
  input  wire logic [N_IRQ-1:0]  irq_req,
  input  wire logic [N_IRQ-1:0]  irq_ack,
  input  wire logic              irq_in_progress,
  // core control outputs
  output logic                   core_run,
  output logic                   core_halted,
  output logic                   core_reset_hold,
  output logic                   core_disable,
  output logic                   emu_enabled,
  output logic                   irq_allow,
  output logic [N_IRQ-1:0]       irq_pend,
  output logic [MODE_W-1:0]      op_mode
);

  // ****************************************************************
  // mode decode
  // ****************************************************************
  function automatic logic [MODE_W-1:0] mode_of(input logic t,
                                                input logic p1,
                                                input logic p0);
    logic [MODE_W-1:0] m;
    m = MODE_NORMAL;
    if (t)
      m = MODE_EMU;
    else
    begin
      case ({p1, p0})
        2'h0:    m = MODE_PERIPH;
        2'h1:    m = MODE_TEST;
        2'h2:    m = MODE_WAIT;
        default: m = MODE_NORMAL;
      endcase
    end
    return m;
  endfunction

  // ****************************************************************
  // link domain: trst synchroniser, command toggle, halted status
  // ****************************************************************
  logic             lk_rst_m_r, lk_rst_s_r;
  logic             lk_tog_r;
  logic [CMD_W-1:0] lk_code_r;
  logic             lk_irq_r;
  logic             lk_ack_m_r, lk_ack_s_r;
  logic             lk_halt_m_r;
  logic             ack_r;
  logic             halted_r;

  always_ff @(posedge tck)
  begin
    lk_rst_m_r <= trst;
    lk_rst_s_r <= lk_rst_m_r;
  end

  always_ff @(posedge tck)
  begin
    if (!lk_rst_s_r)
    begin
      lk_ack_m_r <= 1'b0;
      lk_ack_s_r <= 1'b0;
    end
    else
    begin
      lk_ack_m_r <= ack_r;
      lk_ack_s_r <= lk_ack_m_r;
    end
  end

  // word is held stable until the core side has echoed the toggle
  always_ff @(posedge tck)
  begin
    if (!lk_rst_s_r)
    begin
      lk_tog_r  <= 1'b0;
      lk_code_r <= CMD_HALT;
      lk_irq_r  <= 1'b0;
      cmd_ready <= 1'b0;
    end
    else if (cmd_valid && cmd_ready)
    begin
      lk_tog_r  <= ~lk_tog_r;
      lk_code_r <= cmd_code;
      lk_irq_r  <= cmd_step_irq_allow;
      cmd_ready <= 1'b0;
    end
    else
      cmd_ready <= (lk_tog_r == lk_ack_s_r);
  end

  always_ff @(posedge tck)
  begin
    lk_halt_m_r <= halted_r;
    link_halted <= lk_halt_m_r;
  end

  // ****************************************************************
  // core domain synchronisers
  // ****************************************************************
  logic trst_m_r, trst_s_r, trst_d_r;
  logic p0_m_r, p0_s_r, p1_m_r, p1_s_r;
  logic go_m_r, go_s_r;
  logic tog_m_r, tog_s_r;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      trst_m_r <= 1'b0;
      trst_s_r <= 1'b0;
      trst_d_r <= 1'b0;
      p0_m_r   <= 1'b1;
      p0_s_r   <= 1'b1;
      p1_m_r   <= 1'b1;
      p1_s_r   <= 1'b1;
      go_m_r   <= 1'b0;
      go_s_r   <= 1'b0;
      tog_m_r  <= 1'b0;
      tog_s_r  <= 1'b0;
    end
    else
    begin
      trst_m_r <= trst;
      trst_s_r <= trst_m_r;
      trst_d_r <= trst_s_r;
      p0_m_r   <= debug_pin0_i;
      p0_s_r   <= p0_m_r;
      p1_m_r   <= debug_pin1_i;
      p1_s_r   <= p1_m_r;
      go_m_r   <= sync_go;
      go_s_r   <= go_m_r;
      tog_m_r  <= lk_tog_r;
      tog_s_r  <= tog_m_r;
    end
  end

  // ****************************************************************
  // command receive: toggle compare, echo as ack
  // ****************************************************************
  logic             cmd_new;
  logic [CMD_W-1:0] cmd_now;

  assign cmd_new = trst_s_r && (tog_s_r != ack_r);
  assign cmd_now = lk_code_r;

  // cleared while test reset is low so a link reset cannot fake a command
  always_ff @(posedge clk)
  begin
    if (!nrst || !trst_s_r)
      ack_r <= 1'b0;
    else
      ack_r <= tog_s_r;
  end

  // ****************************************************************
  // operating mode latch
  // ****************************************************************
  logic [1:0] cap_cnt_r;
  logic       cap_done_r;
  logic       trst_rise;

  assign trst_rise = trst_s_r && !trst_d_r;

  // power-up strap taken once the synchronisers hold settled pin levels
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cap_cnt_r  <= 2'h0;
      cap_done_r <= 1'b0;
      op_mode    <= MODE_NORMAL;
    end
    else if (trst_rise)
    begin
      cap_done_r <= 1'b1;
      op_mode    <= mode_of(1'b1, p1_s_r, p0_s_r);
    end
    else if (!cap_done_r)
    begin
      if (cap_cnt_r == 2'(SYNC_STAGES))
      begin
        cap_done_r <= 1'b1;
        op_mode    <= mode_of(trst_s_r, p1_s_r, p0_s_r);
      end
      else
        cap_cnt_r <= cap_cnt_r + 2'h1;
    end
    // otherwise the mode is frozen whatever the pins do
  end

  logic emu_en;
  assign emu_en = (op_mode == MODE_EMU);

  // ****************************************************************
  // break sources
  // ****************************************************************
  dec_state_e state_r;
  logic       brk_pend_r;
  logic       step_irq_r;
  logic       user_halt;
  logic       stop_ok;
  logic       brk_src;
  logic       brk_any;

  assign user_halt = cmd_new && (cmd_now == CMD_HALT);
  assign stop_ok   = emu_en && (state_r != ST_FREE);
  assign brk_src   = user_halt
                   | (stop_ok & (hw_bp_d2
                               | sw_break_insn_d2
                               | watch_req
                               | (|(ext_trig & ext_trig_en))
                               | halt_insn_d2));
  assign brk_any   = brk_src || brk_pend_r;

  always_ff @(posedge clk)
  begin
    if (!nrst || state_r == ST_HALT)
      brk_pend_r <= 1'b0;
    else if (brk_src)
      brk_pend_r <= 1'b1;
  end

  // ****************************************************************
  // execution state machine
  // ****************************************************************
  dec_state_e state_nxt;
  logic       take_brk;

  // a service already under way finishes its entry first
  assign take_brk = brk_any && insn_boundary && !irq_in_progress;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_HALT:
      begin
        if (cmd_new)
        begin
          case (cmd_now)
            CMD_STEP: state_nxt = ST_STEP;
            CMD_RUN:  state_nxt = ST_RUN;
            CMD_FREE: state_nxt = ST_FREE;
            CMD_SYNC: state_nxt = ST_SYNC;
            default:  state_nxt = ST_HALT;
          endcase
        end
      end
      ST_STEP:
        if (insn_boundary && !irq_in_progress)
          state_nxt = ST_HALT;
      ST_RUN, ST_FREE:
        if (take_brk)
          state_nxt = ST_HALT;
      ST_SYNC:
        if (user_halt)
          state_nxt = ST_HALT;
        else if (go_s_r)
          state_nxt = ST_RUN;
      default:
        state_nxt = ST_HALT;
    endcase
  end

  // without a debugger the core starts free running
  always_ff @(posedge clk)
  begin
    if (!nrst)
      state_r <= ST_FREE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      step_irq_r <= 1'b0;
    else if (state_r == ST_HALT && cmd_new && cmd_now == CMD_STEP)
      step_irq_r <= lk_irq_r;
  end

  // ****************************************************************
  // interrupt gating and pending capture
  // ****************************************************************
  logic             irq_ok_nxt;
  logic [N_IRQ-1:0] irq_d_r;
  logic             blocked;

  always_comb
  begin
    case (state_nxt)
      ST_RUN, ST_FREE: irq_ok_nxt = !brk_any;
      ST_STEP:         irq_ok_nxt = step_irq_r;
      default:         irq_ok_nxt = 1'b0;
    endcase
  end

  assign blocked = (state_r == ST_HALT) || (state_r == ST_SYNC)
                || (state_r == ST_STEP && !step_irq_r);

  // only the first instance is kept; the set beats an ack
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      irq_d_r  <= '0;
      irq_pend <= '0;
    end
    else
    begin
      irq_d_r  <= irq_req;
      irq_pend <= (irq_pend & ~irq_ack)
                | (blocked ? (irq_req & ~irq_d_r) : '0);
    end
  end

  // ****************************************************************
  // core control outputs
  // ****************************************************************
  logic wait_rel_r;

  // any debugger command counts as the outside release
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wait_rel_r <= 1'b0;
    else if (cmd_new)
      wait_rel_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      core_run        <= 1'b0;
      core_halted     <= 1'b0;
      core_reset_hold <= 1'b1;
      core_disable    <= 1'b0;
      emu_enabled     <= 1'b0;
      irq_allow       <= 1'b0;
      halted_r        <= 1'b0;
    end
    else
    begin
      core_run        <= (state_nxt == ST_RUN) || (state_nxt == ST_FREE)
                      || (state_nxt == ST_STEP);
      core_halted     <= (state_nxt == ST_HALT);
      core_reset_hold <= !cap_done_r
                      || (op_mode == MODE_WAIT && !wait_rel_r);
      core_disable    <= (op_mode == MODE_PERIPH);
      emu_enabled     <= emu_en;
      irq_allow       <= irq_ok_nxt;
      halted_r        <= (state_nxt == ST_HALT);
    end
  end

  // pins are only sensed; pulls live in the pad ring
  always_ff @(posedge clk)
  begin
    debug_pin0_o  <= 1'b0;
    debug_pin0_oe <= 1'b0;
    debug_pin1_o  <= 1'b0;
    debug_pin1_oe <= 1'b0;
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_step_cmd;
    state_r == ST_HALT && cmd_new && cmd_now == CMD_STEP;
  endsequence
  sequence s_step_end;
    state_r == ST_STEP && insn_boundary && !irq_in_progress;
  endsequence

  mode_latch_a: assert property (trst_rise |=> op_mode == MODE_EMU)
    else $error("mode not emulation after test reset rise");
  mode_hold_a: assert property (cap_done_r && !trst_rise
    |=> $stable(op_mode))
    else $error("latched mode changed without test reset rise");
  periph_a: assert property (op_mode == MODE_PERIPH
    |=> core_disable)
    else $error("peripheral mode did not disable core");
  wait_hold_a: assert property (op_mode == MODE_WAIT && !wait_rel_r
    |=> core_reset_hold)
    else $error("wait mode released reset early");
  brk_halt_a: assert property ((state_r == ST_RUN) && take_brk
    |=> core_halted && state_r == ST_HALT)
    else $error("break at boundary did not halt");
  halt_irq_a: assert property (state_r == ST_HALT ##1
    state_r == ST_HALT |-> !irq_allow)
    else $error("interrupt allowed while halted");
  step_go_a: assert property (s_step_cmd
    |=> state_r == ST_STEP && core_run)
    else $error("step command did not start the step");
  step_ret_a: assert property (s_step_end
    |=> state_r == ST_HALT && core_halted)
    else $error("step did not return to halt");
  step_irq_a: assert property (state_r == ST_STEP && !step_irq_r
    ##1 state_r == ST_STEP |-> !irq_allow)
    else $error("step serviced interrupt without allow");
  free_ign_a: assert property (state_r == ST_FREE && !user_halt
    && !brk_pend_r |=> !brk_pend_r)
    else $error("free run accepted a break source");
  sync_wait_a: assert property (state_r == ST_SYNC && !go_s_r
    |=> state_r != ST_RUN)
    else $error("synchronous run started before sync");
  pend_keep_a: assert property (blocked && irq_pend[0]
    && !irq_ack[0] |=> irq_pend[0])
    else $error("pending interrupt lost while halted");
  prio_a: assert property (state_r == ST_RUN && brk_src
    |=> !irq_allow)
    else $error("interrupt allowed beside a debug event");

endmodule

// file: dec_link_host.sv
`timescale 1ns/100ps

// ****************************************************************
// scan controller model on the link side
// ****************************************************************
module dec_link_host
  import dec_pkg::*;
(
  // link pins driven by the controller
  output logic             tck,
  output logic             trst,
  output logic             cmd_valid,
  output logic [CMD_W-1:0] cmd_code,
  output logic             cmd_step_irq_allow,
  // status back from the device
  input  wire logic        cmd_ready,
  input  wire logic        link_halted
);
  int unsigned fails;

  // tck stands still outside frames, so clock edges come only from here
  initial
  begin
    tck = 1'b0;
    trst = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = '0;
    cmd_step_irq_allow = 1'b0;
    fails = 0;
  end

  task automatic pulse(input int n);
    repeat (n)
    begin
      #32 tck = 1'b1;
      #32 tck = 1'b0;
    end
  endtask

  // trst stays low through power-up and only rises on demand
  task automatic set_trst(input logic lvl);
    trst = lvl;
    pulse(4);
  endtask

  // offer a command, hold it until taken, wait for ready again
  task automatic send(input logic [CMD_W-1:0] code, input logic allow);
    logic taken;
    int   k;
    taken = 1'b0;
    cmd_code = code;
    cmd_step_irq_allow = allow;
    cmd_valid = 1'b1;
    for (k = 0; k < 40 && !taken; k++)
    begin
      #32 taken = (cmd_ready === 1'b1);
      tck = 1'b1;
      #1;
      if (taken)
      begin
        // released lines show the inverse, not the last value
        cmd_valid = 1'b0;
        cmd_code = ~code;
        cmd_step_irq_allow = ~allow;
      end
      #31 tck = 1'b0;
    end
    for (k = 0; k < 40 && cmd_ready !== 1'b1; k++)
      pulse(1);
    if (!taken || cmd_ready !== 1'b1)
      fails++;
  endtask
endmodule

// file: tb_top.sv
`timescale 1ns/100ps

module tb_top
  import dec_pkg::*;
;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             tck;
  logic             trst;
  logic             cmd_valid;
  logic [CMD_W-1:0] cmd_code;
  logic             cmd_step_irq_allow;
  logic             cmd_ready;
  logic             link_halted;
  logic             p0_o, p0_oe, p1_o, p1_oe;
  logic             p0_low = 1'b0;
  logic             p1_low = 1'b0;
  logic             insn_boundary = 1'b0;
  logic [4:0]       src = '0;
  logic [3:0]       trig_en = 4'h0;
  logic             sync_go = 1'b0;
  logic [7:0]       irq_req = 8'h00;
  logic [7:0]       irq_ack = 8'h00;
  logic             irq_busy = 1'b0;
  logic             core_run, core_halted, core_reset_hold, core_disable;
  logic             emu_enabled, irq_allow;
  logic [7:0]       irq_pend;
  logic [MODE_W-1:0] op_mode;
  int               n_errors = 0;
  int               checks_done = 0;

  always #5 clk = ~clk;

  dec_link_host i_host (
    .tck(tck), .trst(trst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_step_irq_allow(cmd_step_irq_allow), .cmd_ready(cmd_ready),
    .link_halted(link_halted));

  // pins pulled up unless the pin or outside hardware pulls low
  dec_exec_ctrl #(.N_IRQ(8), .N_TRIG(4)) i_dut (
    .clk(clk), .nrst(nrst), .tck(tck), .trst(trst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_step_irq_allow(cmd_step_irq_allow), .cmd_ready(cmd_ready),
    .link_halted(link_halted),
    .debug_pin0_i(p0_oe ? p0_o : !p0_low), .debug_pin0_o(p0_o),
    .debug_pin0_oe(p0_oe),
    .debug_pin1_i(p1_oe ? p1_o : !p1_low), .debug_pin1_o(p1_o),
    .debug_pin1_oe(p1_oe),
    .insn_boundary(insn_boundary), .hw_bp_d2(src[0]),
    .sw_break_insn_d2(src[1]), .halt_insn_d2(src[2]), .watch_req(src[3]),
    .ext_trig({3'h0, src[4]}), .ext_trig_en(trig_en), .sync_go(sync_go),
    .irq_req(irq_req), .irq_ack(irq_ack), .irq_in_progress(irq_busy),
    .core_run(core_run), .core_halted(core_halted),
    .core_reset_hold(core_reset_hold), .core_disable(core_disable),
    .emu_enabled(emu_enabled), .irq_allow(irq_allow), .irq_pend(irq_pend),
    .op_mode(op_mode));

  // ****************************************************************
  // shared helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    nrst = 1'b0;
    tick(5);
    nrst = 1'b1;
    tick(8);
  endtask

  // break source pulse, then a boundary, then look at the halt
  task automatic brk(input logic [4:0] m, input logic exp);
    src = m;
    tick(1);
    src = '0;
    insn_boundary = 1'b1;
    tick(1);
    insn_boundary = 1'b0;
    tick(2);
    chk("core_halted", 8'(exp), 8'(core_halted));
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_powerup();
    do_reset();
    // link side resets only while tck runs with trst low
    i_host.pulse(3);
    chk("op_mode", 8'(MODE_NORMAL), 8'(op_mode));
    chk("emu_enabled", 8'h00, 8'(emu_enabled));
    chk("reset_hold", 8'h00, 8'(core_reset_hold));
    chk("pin_oe", 8'h00, 8'({p1_oe, p0_oe}));
    chk("pin_o", 8'h00, 8'({p1_o, p0_o}));
    brk(5'h04, 1'b0);
    p0_low = 1'b1;
    p1_low = 1'b1;
    do_reset();
    chk("op_mode", 8'(MODE_PERIPH), 8'(op_mode));
    chk("core_disable", 8'h01, 8'(core_disable));
    p1_low = 1'b0;
    do_reset();
    // pin0 pulled low only while power-up reset lasts
    p0_low = 1'b0;
    chk("op_mode", 8'(MODE_WAIT), 8'(op_mode));
    tick(30);
    chk("reset_hold", 8'h01, 8'(core_reset_hold));
    p1_low = 1'b1;
    do_reset();
    chk("op_mode", 8'(MODE_TEST), 8'(op_mode));
  endtask

  task automatic t_emu();
    p0_low = 1'b1;
    p1_low = 1'b1;
    i_host.set_trst(1'b1);
    tick(6);
    chk("op_mode", 8'(MODE_EMU), 8'(op_mode));
    chk("emu_enabled", 8'h01, 8'(emu_enabled));
    i_host.send(CMD_HALT, 1'b0);
    // the user halt waits for the next boundary like any break
    brk(5'h00, 1'b1);
    chk("reset_hold", 8'h00, 8'(core_reset_hold));
    chk("core_halted", 8'h01, 8'(core_halted));
    i_host.pulse(3);
    chk("link_halted", 8'h01, 8'(link_halted));
    p0_low = 1'b0;
    p1_low = 1'b0;
    tick(10);
    chk("op_mode", 8'(MODE_EMU), 8'(op_mode));
  endtask

  task automatic t_halt_irq();
    irq_req = 8'h01;
    tick(2);
    chk("irq_pend", 8'h01, irq_pend);
    chk("irq_allow", 8'h00, 8'(irq_allow));
    irq_req = 8'h00;
    tick(1);
    irq_req = 8'h01;
    tick(2);
    irq_ack = 8'h01;
    tick(1);
    irq_ack = 8'h00;
    tick(1);
    // the repeat was never latched, so one ack empties it
    chk("irq_pend", 8'h00, irq_pend);
    irq_req = 8'h00;
  endtask

  task automatic t_step();
    for (int a = 0; a < 2; a++)
    begin
      i_host.send(CMD_STEP, a[0]);
      tick(3);
      chk("core_run", 8'h01, 8'(core_run));
      chk("irq_allow", 8'(a[0]), 8'(irq_allow));
      brk(5'h00, 1'b1);
      chk("core_run", 8'h00, 8'(core_run));
    end
  endtask

  task automatic t_run();
    trig_en = 4'h1;
    for (int i = 0; i < 5; i++)
    begin
      i_host.send(CMD_RUN, 1'b0);
      tick(4);
      chk("irq_allow", 8'h01, 8'(irq_allow));
      brk(5'(1 << i), 1'b1);
    end
    trig_en = 4'h0;
    i_host.send(CMD_RUN, 1'b0);
    tick(4);
    brk(5'h10, 1'b0);
    // break meets an interrupt: the break wins
    src = 5'h01;
    irq_req = 8'h02;
    tick(1);
    src = '0;
    chk("irq_allow", 8'h00, 8'(irq_allow));
    irq_busy = 1'b1;
    brk(5'h00, 1'b0);
    irq_busy = 1'b0;
    brk(5'h00, 1'b1);
    irq_req = 8'h00;
  endtask

  task automatic t_free_sync();
    trig_en = 4'h1;
    i_host.send(CMD_FREE, 1'b0);
    tick(4);
    for (int i = 0; i < 5; i++)
      brk(5'(1 << i), 1'b0);
    i_host.send(CMD_HALT, 1'b0);
    brk(5'h00, 1'b1);
    i_host.send(CMD_SYNC, 1'b0);
    tick(8);
    chk("core_run", 8'h00, 8'(core_run));
    sync_go = 1'b1;
    tick(6);
    chk("core_run", 8'h01, 8'(core_run));
  endtask

  initial
  begin
    t_powerup();
    t_emu();
    t_halt_irq();
    t_step();
    t_run();
    t_free_sync();
    chk("link_timeouts", 8'h00, 8'(i_host.fails));
    summarize();
  end

  // whole run is about 6 us
  initial
  begin
    #400000;
    n_errors++;
    summarize();
  end
endmodule
